// ---- rco_pkg.sv ----
// constants and types for the reference clock output block
// Notes on behaviour
// RQ1: the block runs only from the system clock tick, whatever the oscillator mode.
// RQ2: the block works only while its block enable bit is one.
// RQ3: the divided clock reaches the pin only when pin drive enable is also set.
// RQ4: a three-bit divide select picks one of eight division ratios.
// RQ5: a two-bit duty select sets the high time of the divided clock.
// RQ6: the edge limit bit switches pin slew limiting; clearing it removes limiting.
// RQ7: undivided ratio copies the source duty, but 0% duty still holds low.
// RQ8: at divide by two, 25% and 75% duty depend on the source waveform; the divider gives a fixed 50% for both.
// RQ9: any reset disables the block and returns all settings to defaults.
// RQ10: software programs divide, duty and slew before enabling the pin after reset.
// RQ11: in crystal oscillator modes the pin serves the oscillator; no clock output.
// RQ12: an enabled system-clock/4 output takes the pin before this block, except in crystal oscillator modes.
// RQ13: in sleep the block makes no edges because the system clock stops.
// RQ14: on entering sleep the output freezes at its level until wake.
// RQ15: duty codes: 11 is 75%, 10 is 50%, 01 is 25%, 00 holds low.
// RQ16: disabled or pin drive off: output held low and divider count cleared.
package rco_pkg;
    // register byte offsets
    localparam logic [3:0] RCO_CTRL_OFS = 4'h0;
    localparam logic [3:0] RCO_STAT_OFS = 4'h4;
    // control field positions
    localparam int RCO_EN_BIT = 7;
    localparam int RCO_OE_BIT = 6;
    localparam int RCO_SLR_BIT = 5;
    localparam int RCO_DC_LSB = 3;
    localparam int RCO_DIV_LSB = 0;
    // control reset value: edge limit on, duty 75%, undivided
    localparam logic [7:0] RCO_CTRL_RST = 8'h38;
    // status field positions
    localparam int RCO_ST_PIN_BIT = 0;
    localparam int RCO_ST_OE_BIT = 1;
    localparam int RCO_ST_BLOCKED_BIT = 2;
    localparam int RCO_ST_SLEEP_BIT = 3;
    // duty codes
    localparam logic [1:0] RCO_DUTY_0 = 2'h0;
    localparam logic [1:0] RCO_DUTY_25 = 2'h1;
    localparam logic [1:0] RCO_DUTY_50 = 2'h2;
    localparam logic [1:0] RCO_DUTY_75 = 2'h3;
    // oscillator modes that occupy the shared pin
    localparam logic [2:0] RCO_OSC_LOW_POWER_CRYSTAL = 3'h0;
    localparam logic [2:0] RCO_OSC_MEDIUM_CRYSTAL = 3'h1;
    localparam logic [2:0] RCO_OSC_HIGH_SPEED_CRYSTAL = 3'h2;

    typedef struct packed {
        logic refclk_block_enable;
        logic refclk_pin_drive_enable;
        logic refclk_edge_limit;
        logic [1:0] refclk_duty_select;
        logic [2:0] refclk_divide_select;
    } rco_ctrl_s;

    typedef struct packed {
        logic [2:0] osc_mode;
        logic sysclk_quarter_out_enable;
    } rco_cfg_s;
endpackage

// ---- rco_divider.sv ----
// programmable divider with duty selection for the reference clock
module rco_divider
    import rco_pkg::*;
#(
    parameter int unsigned SEL_W = 3
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_n,
    // control
    input wire logic i_run,
    input wire logic i_freeze,
    input wire logic i_src_tick,
    input wire logic [SEL_W-1:0] i_div_sel,
    input wire logic [1:0] i_duty,
    // divided waveform
    output logic o_wave
);
    localparam int unsigned CNT_W = (1 << SEL_W) - 1;

    generate
        if (SEL_W < 1 || SEL_W > 4) begin : g_bad
            $error("rco_divider: SEL_W must be 1 to 4");
        end
    endgenerate

    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] period_m1;
    logic [CNT_W:0] thr;
    logic [CNT_W+2:0] prod;
    logic [CNT_W-1:0] next_cnt;

    // period is 2 to the power of the select, in source ticks
    always_comb begin
        period_m1 = ~({CNT_W{1'b1}} << i_div_sel);
        prod = ({2'h0, 1'b0, period_m1} + (CNT_W+3)'(1)) * (CNT_W+3)'(i_duty);
        thr = prod[CNT_W+2:2];
        // RQ8 half-ratio quarter duty
        if (i_div_sel == SEL_W'(1) && i_duty[0]) begin
            thr = (CNT_W+1)'(1);
        end
        next_cnt = (cnt == period_m1) ? '0 : cnt + CNT_W'(1);
    end

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            cnt <= '0;
            o_wave <= 1'b0;
        // RQ16 idle held low
        end else if (!i_run) begin
            cnt <= '0;
            o_wave <= 1'b0;
        // RQ14 freeze in sleep
        end else if (i_freeze) begin
            cnt <= cnt;
        // RQ7 undivided copies source
        end else if (i_div_sel == '0) begin
            cnt <= '0;
            o_wave <= (i_duty != RCO_DUTY_0) && i_src_tick;
        // RQ4 RQ5 RQ15 divide and duty
        end else if (i_src_tick) begin
            cnt <= next_cnt;
            o_wave <= ({1'b0, cnt} < thr);
        end
    end
endmodule

// ---- rco_refclk_top.sv ----
// reference clock output block with wishbone register access
module rco_refclk_top
    import rco_pkg::*;
(
    // clock and reset
    input wire logic i_ref_clk,
    input wire logic i_rstn,
    // system clock tick and sleep, same clock domain
    input wire logic i_sys_clk_tick,
    input wire logic i_sleep,
    input wire logic i_sysclk_quarter_out,
    // configuration pins
    input wire rco_pkg::rco_cfg_s i_cfg,
    // wishbone slave
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [3:0] i_wb_adr,
    input wire logic [3:0] i_wb_sel,
    input wire logic [31:0] i_wb_dat,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    // shared output pin
    output logic o_refclk_out_pin,
    output logic o_refclk_out_oe,
    output logic o_refclk_edge_limit
);
    import rco_pkg::*;

    logic rst_meta;
    logic rst_n;
    rco_cfg_s cfg_meta;
    rco_cfg_s cfg;
    rco_ctrl_s ctrl;
    logic wave;
    logic blocked;
    logic quarter_wins;
    logic run;
    logic wb_req;
    logic next_pin;
    logic next_oe;

    // reset release through two flops
    always_ff @(posedge i_ref_clk or negedge i_rstn) begin
        if (!i_rstn) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
        end
    end

    // configuration pin synchroniser
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_meta <= '0;
            cfg <= '0;
        end else begin
            cfg_meta <= i_cfg;
            cfg <= cfg_meta;
        end
    end

    // RQ11 crystal modes own pin
    assign blocked = (cfg.osc_mode == RCO_OSC_LOW_POWER_CRYSTAL)
                  || (cfg.osc_mode == RCO_OSC_MEDIUM_CRYSTAL)
                  || (cfg.osc_mode == RCO_OSC_HIGH_SPEED_CRYSTAL);
    assign quarter_wins = !blocked && cfg.sysclk_quarter_out_enable;
    // RQ2 RQ3 enable gating
    assign run = ctrl.refclk_block_enable && ctrl.refclk_pin_drive_enable;

    // RQ1 RQ13 source is the system tick
    rco_divider #(
        .SEL_W(3)
    ) u_div (
        .i_clk(i_ref_clk),
        .i_rst_n(rst_n),
        .i_run(run),
        .i_freeze(i_sleep),
        .i_src_tick(i_sys_clk_tick),
        .i_div_sel(ctrl.refclk_divide_select),
        .i_duty(ctrl.refclk_duty_select),
        .o_wave(wave)
    );

    // pin selection by priority
    always_comb begin
        if (blocked) begin
            next_pin = 1'b0;
            next_oe = 1'b0;
        // RQ12 quarter output first
        end else if (quarter_wins) begin
            next_pin = i_sysclk_quarter_out;
            next_oe = 1'b1;
        end else begin
            next_pin = wave && run;
            next_oe = run;
        end
    end

    // RQ14 pin holds during sleep
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_refclk_out_pin <= 1'b0;
            o_refclk_out_oe <= 1'b0;
        end else if (!i_sleep) begin
            o_refclk_out_pin <= next_pin;
            o_refclk_out_oe <= next_oe;
        end
    end

    // RQ6 slew limit follows bit
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_refclk_edge_limit <= RCO_CTRL_RST[RCO_SLR_BIT];
        end else begin
            o_refclk_edge_limit <= ctrl.refclk_edge_limit;
        end
    end

    assign wb_req = i_wb_cyc && i_wb_stb && !o_wb_ack;

    // RQ9 reset restores defaults
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl <= rco_ctrl_s'(RCO_CTRL_RST);
        end else if (wb_req && i_wb_we && i_wb_sel[0] && i_wb_adr == RCO_CTRL_OFS) begin
            ctrl <= rco_ctrl_s'(i_wb_dat[7:0]);
        end
    end

    // bus answer one cycle after request
    always_ff @(posedge i_ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            o_wb_ack <= 1'b0;
            o_wb_dat <= 32'h0;
        end else begin
            o_wb_ack <= wb_req;
            o_wb_dat <= 32'h0;
            if (wb_req && !i_wb_we) begin
                unique case (i_wb_adr)
                    RCO_CTRL_OFS: o_wb_dat <= {24'h0, ctrl};
                    RCO_STAT_OFS: begin
                        o_wb_dat[RCO_ST_PIN_BIT] <= o_refclk_out_pin;
                        o_wb_dat[RCO_ST_OE_BIT] <= o_refclk_out_oe;
                        o_wb_dat[RCO_ST_BLOCKED_BIT] <= blocked || quarter_wins;
                        o_wb_dat[RCO_ST_SLEEP_BIT] <= i_sleep;
                    end
                    default: o_wb_dat <= 32'h0;
                endcase
            end
        end
    end

    // checks
    default clocking cb @(posedge i_ref_clk);
    endclocking
    default disable iff (!rst_n);

    AST_CRYSTAL_NO_DRIVE: assert property (  // RQ11
        $past(blocked) && !$past(i_sleep) |-> !o_refclk_out_oe)
        else $error("pin driven in crystal mode");

    AST_QUARTER_PRIORITY: assert property (  // RQ12
        $past(quarter_wins) && !$past(i_sleep)
        |-> o_refclk_out_oe && o_refclk_out_pin == $past(i_sysclk_quarter_out))
        else $error("quarter output lost the pin");

    AST_DISABLED_LOW: assert property (  // RQ2
        !ctrl.refclk_block_enable ##1 !ctrl.refclk_block_enable |-> !wave)
        else $error("divider active while disabled");

    AST_NO_OE_NO_DRIVE: assert property (  // RQ3
        !$past(run) && !$past(blocked) && !$past(quarter_wins) && !$past(i_sleep)
        |-> !o_refclk_out_oe && !o_refclk_out_pin)
        else $error("pin driven without pin drive enable");

    AST_SLEEP_FREEZE: assert property (  // RQ14
        i_sleep ##1 i_sleep |-> $stable(o_refclk_out_pin) && $stable(o_refclk_out_oe))
        else $error("pin moved during sleep");

    AST_SLEW_FOLLOWS: assert property (  // RQ6
        ##1 o_refclk_edge_limit == $past(ctrl.refclk_edge_limit))
        else $error("edge limit not following control");

    AST_ZERO_DUTY: assert property (  // RQ15
        ctrl.refclk_duty_select == RCO_DUTY_0 ##1 ctrl.refclk_duty_select == RCO_DUTY_0
        ##1 ctrl.refclk_duty_select == RCO_DUTY_0 |-> !wave)
        else $error("zero duty gave a high output");

    AST_UNDIVIDED_COPY: assert property (  // RQ7
        run && !i_sleep && ctrl.refclk_divide_select == 3'h0
        && ctrl.refclk_duty_select != RCO_DUTY_0
        |=> wave == $past(i_sys_clk_tick))
        else $error("undivided output does not copy source");

    AST_HALF_PERIOD: assert property (  // RQ4
        run && !i_sleep && ctrl.refclk_divide_select == 3'h1
        && ctrl.refclk_duty_select == RCO_DUTY_50 && $rose(wave) && i_sys_clk_tick
        ##1 (!i_sleep && i_sys_clk_tick && $stable(ctrl)) |-> !wave ##1 wave)
        else $error("divide by two waveform wrong");

    AST_ACK_ONE_CYCLE: assert property (
        o_wb_ack |=> !o_wb_ack)
        else $error("ack held more than one cycle");

    AST_ACK_TIMING: assert property (
        i_wb_cyc && i_wb_stb && !o_wb_ack |=> o_wb_ack)
        else $error("request not answered next cycle");

    COV_DIV_RUN: cover property (run && ctrl.refclk_divide_select == 3'h2 && $rose(wave));
    COV_QUARTER: cover property (quarter_wins && o_refclk_out_oe);
    COV_SLEEP: cover property (run && $rose(i_sleep));
    COV_CTRL_WRITE: cover property (wb_req && i_wb_we && i_wb_adr == RCO_CTRL_OFS);
endmodule

// ---- rco_ext_dev.sv ----
// far-side device model: counts high cycles of the received clock
module rco_ext_dev (
    input wire logic i_clk,
    input wire logic i_clr,
    input wire logic i_pin,
    input wire logic i_oe,
    output int o_highs
);
    timeunit 1ns;
    timeprecision 1ps;
    // only a driven pin clocks the device
    always @(posedge i_clk) begin
        if (i_clr) begin
            o_highs <= 0;
        end else if (i_oe === 1'b1 && i_pin === 1'b1) begin
            o_highs <= o_highs + 1;
        end
    end
endmodule

// ---- rco_refclk_top_tb.sv ----
// self-checking bench for the reference clock output block
module rco_refclk_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import rco_pkg::*;
    logic clk = 0, rstn = 0, tick = 1, slp = 0, qout = 0, clr = 0;
    logic cyc = 0, stb = 0, we = 0, ack, pin, oe, slr;
    logic [3:0] adr = 4'h0, sel = 4'h0;
    logic [31:0] dat = 32'h0, rdat, q;
    rco_cfg_s cfg = '{osc_mode: 3'h7, sysclk_quarter_out_enable: 1'b0};
    int error_cnt = 0, checks = 0, seed = 69682, highs, tk;
    logic s, r;
    rco_refclk_top i_rco_refclk_top (.i_ref_clk(clk), .i_rstn(rstn), .i_sys_clk_tick(tick),
        .i_sleep(slp), .i_sysclk_quarter_out(qout), .i_cfg(cfg), .i_wb_cyc(cyc),
        .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(dat),
        .o_wb_dat(rdat), .o_wb_ack(ack), .o_refclk_out_pin(pin), .o_refclk_out_oe(oe),
        .o_refclk_edge_limit(slr));
    rco_ext_dev i_rco_ext_dev (.i_clk(clk), .i_clr(clr), .i_pin(pin), .i_oe(oe),
        .o_highs(highs));
    always #2 clk = ~clk;
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wb(input logic w, input logic [3:0] a, input logic [7:0] d,
                      input logic [3:0] m);
        int n;
        n = 0;
        @(posedge clk);
        cyc <= 1;
        stb <= 1;
        we <= w;
        adr <= a;
        dat <= {24'h0, d};
        sel <= m;
        do begin
            @(posedge clk);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50) chk("ack", 1, 0);
        cyc <= 0;
        stb <= 0;
        we <= 0;
    endtask
    function automatic int exp_highs(input int dv, input int dc, input int t);
        if (dc == 0) return 0;
        if (dv == 0) return t;
        if (dv == 1) return 128;
        return 64 * dc;
    endfunction
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        error_cnt++;
        print_verdict();
    end
    initial begin
        repeat (8) @(posedge clk);
        rstn <= 1;
        repeat (6) @(posedge clk);
        chk("edge_limit", 1, slr);
        wb(0, RCO_CTRL_OFS, 0, 4'hf);
        chk("ctrl", 32'h38, q);
        wb(1, RCO_CTRL_OFS, 8'hc1, 4'he);
        wb(1, 4'hc, 8'hc1, 4'hf);
        wb(0, 4'hc, 0, 4'hf);
        chk("unmapped", 0, q);
        wb(0, RCO_CTRL_OFS, 0, 4'hf);
        chk("ctrl", 32'h38, q);
        chk("oe", 0, oe);
        $display("test reset done");
        for (int dv = 0; dv < 8; dv++) begin
            for (int dc = 0; dc < 4; dc++) begin
                s = $random(seed);
                clr <= 1;
                tick <= 1'(dv != 0);
                // settings before enabling
                wb(1, RCO_CTRL_OFS, {2'b00, s, dc[1:0], dv[2:0]}, 4'h1);
                clr <= 0;
                tk = 0;
                wb(1, RCO_CTRL_OFS, {2'b11, s, dc[1:0], dv[2:0]}, 4'h1);
                chk("edge_limit", s, slr);
                for (int i = 0; i < 253; i++) begin
                    @(posedge clk);
                    if (dv == 0) begin
                        r = (i >= 4 && i < 249) ? 1'($random(seed)) : 1'b0;
                        tick <= r;
                        if (r) tk++;
                    end
                end
                wb(1, RCO_CTRL_OFS, {2'b00, s, dc[1:0], dv[2:0]}, 4'h1);
                tick <= 1;
                repeat (8) @(posedge clk);
                chk("highs", exp_highs(dv, dc, tk), highs);
                chk("oe_off", 0, oe);
            end
        end
        $display("test divide duty done");
        wb(1, RCO_CTRL_OFS, 8'hd7, 4'h1);
        repeat (40) @(posedge clk);
        slp <= 1;
        repeat (2) @(posedge clk);
        s = pin;
        wb(0, RCO_STAT_OFS, 0, 4'hf);
        chk("status_sleep", {28'h0, 3'b101, s}, q);
        repeat (60) @(posedge clk);
        chk("sleep_pin", s, pin);
        slp <= 0;
        $display("test sleep done");
        for (int m = 0; m < 3; m++) begin
            cfg <= '{osc_mode: m[2:0], sysclk_quarter_out_enable: 1'b0};
            repeat (8) @(posedge clk);
            chk("crystal_oe", 0, oe);
        end
        cfg <= '{osc_mode: 3'h7, sysclk_quarter_out_enable: 1'b1};
        qout <= 1;
        repeat (8) @(posedge clk);
        chk("quarter_pin", 1, pin);
        wb(0, RCO_STAT_OFS, 0, 4'hf);
        chk("status_quarter", 32'h7, q);
        qout <= 0;
        repeat (3) @(posedge clk);
        chk("quarter_pin", 0, pin);
        $display("test pin conflict done");
        rstn <= 0;
        repeat (8) @(posedge clk);
        rstn <= 1;
        repeat (6) @(posedge clk);
        chk("edge_limit", 1, slr);
        wb(0, RCO_CTRL_OFS, 0, 4'hf);
        chk("ctrl", 32'h38, q);
        $display("test second reset done");
        print_verdict();
    end
endmodule
